// *** shared/phy_mgmt_pkg.sv ***
`default_nettype none
package phy_mgmt_pkg;
  // Register indexes
  localparam logic [4:0] IDX_LINK_CONTROL       = 5'h00;
  localparam logic [4:0] IDX_LINK_STATUS        = 5'h01;
  localparam logic [4:0] IDX_OUI_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] IDX_OUI_MODEL_REVISION = 5'h03;
  localparam logic [4:0] IDX_AN_ADVERTISE       = 5'h04;
  localparam logic [4:0] IDX_AN_PARTNER         = 5'h05;
  localparam logic [4:0] IDX_AN_EXPANSION       = 5'h06;
  localparam logic [4:0] IDX_MODE_CONTROL       = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_MODES      = 5'h12;
  localparam logic [4:0] IDX_CTRL_STATUS_IND    = 5'h1b;
  localparam logic [4:0] IDX_INT_SOURCE         = 5'h1d;
  localparam logic [4:0] IDX_INT_MASK           = 5'h1e;
  localparam logic [4:0] IDX_SPECIAL_CTRL       = 5'h1f;
  // Control field positions
  localparam int CTL_SOFT_RESET  = 15;
  localparam int CTL_LOOPBACK    = 14;
  localparam int CTL_SPEED_100   = 13;
  localparam int CTL_AN_ENABLE   = 12;
  localparam int CTL_POWER_DOWN  = 11;
  localparam int CTL_AN_RESTART  = 9;
  localparam int CTL_FULL_DUPLEX = 8;
  localparam int CTL_COL_TEST    = 7;
  // Status field positions
  localparam int STS_AN_COMPLETE = 5;
  localparam int STS_REMOTE_FAULT = 4;
  localparam int STS_AN_ABILITY  = 3;
  localparam int STS_LINK_UP     = 2;
  localparam int STS_JABBER      = 1;
  localparam int STS_EXT_CAP     = 0;
  // Reset values
  localparam logic [15:0] CONTROL_RESET   = 16'h3000;
  localparam logic [4:0]  ABILITY_BITS    = 5'h0f;
  // Identifier defaults; values are arbitrary
  localparam logic [15:0] OUI_HIGH_RESET  = 16'h1234;
  localparam logic [15:0] OUI_MODEL_RESET = 16'h5678;
  // Soft reset duration
  localparam int SOFT_RESET_NS     = 1000;
  localparam int CLK_PERIOD_NS     = 100;
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'(SOFT_RESET_NS / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// *** shared/mgmt_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface mgmt_if;
  logic        wr_en;
  logic        rd_en;
  logic [4:0]  index;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        hit;
  modport master (output wr_en, output rd_en, output index, output wdata,
                  input rdata, input hit);
  modport decoder (input wr_en, input rd_en, input index, input wdata,
                   output rdata, output hit);
endinterface
`default_nettype wire

// *** verilog/phy_index_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
module phy_index_decode (
  mgmt_if.decoder bus,
  // Register words
  input  wire logic [15:0] control_i,
  input  wire logic [15:0] status_i,
  input  wire logic [15:0] oui_high_i,
  input  wire logic [15:0] oui_model_i,
  // Decoded strobes
  output logic             sel_control_o,
  output logic             sel_status_o,
  output logic             sel_oui_high_o,
  output logic             sel_oui_model_o
);
  always_comb begin
    sel_control_o   = bus.index == phy_mgmt_pkg::IDX_LINK_CONTROL;
    sel_status_o    = bus.index == phy_mgmt_pkg::IDX_LINK_STATUS;
    sel_oui_high_o  = bus.index == phy_mgmt_pkg::IDX_OUI_IDENTIFIER_HIGH;
    sel_oui_model_o = bus.index == phy_mgmt_pkg::IDX_OUI_MODEL_REVISION;
    bus.hit = (bus.index <= phy_mgmt_pkg::IDX_AN_EXPANSION)
           || (bus.index == phy_mgmt_pkg::IDX_MODE_CONTROL)
           || (bus.index == phy_mgmt_pkg::IDX_SPECIAL_MODES)
           || (bus.index == phy_mgmt_pkg::IDX_CTRL_STATUS_IND)
           || (bus.index >= phy_mgmt_pkg::IDX_INT_SOURCE);
    bus.rdata = 16'h0000;
    unique case (1'b1)
      sel_control_o:   bus.rdata = control_i;
      sel_status_o:    bus.rdata = status_i;
      sel_oui_high_o:  bus.rdata = oui_high_i;
      sel_oui_model_o: bus.rdata = oui_model_i;
      default:         bus.rdata = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// *** verilog/phy_mgmt_register_set.sv ***
// Operation
// - Registers reached only by index through the MAC management access/data path.
// - Decode indexes 0-6, 17, 18, 27, 29-31; 0-3 implemented here.
// - Control bit 15 starts soft reset and clears itself when done.
// - Kept-over-soft-reset fields survive only a bit-15 reset.
// - Control bit 14 selects loopback, resets to 0.
// - Control bit 13 forces 100 Mb/s, resets 1, ignored under auto-negotiation.
// - Control bit 12 enables auto-negotiation, resets 1, overrides speed and duplex.
// - Control bit 11 selects general power-down, resets 0.
// - Control bit 9 restarts auto-negotiation and clears itself.
// - Control bit 8 forces full duplex, resets 0, ignored under auto-negotiation.
// - Status bits 15-11 report fixed abilities: T4 absent, others present.
// - Status bit 5 shows auto-negotiation complete.
// - Status bit 4 latches high on remote fault, resets 0.
// - Status bits 3 and 0 read constant 1.
// - Status bit 2 shows link, latches low, resets 0.
// - Status bit 1 latches high on jabber, resets 0.
// - Identifier index 2 holds OUI bits 3 to 18.
// - Identifier index 3 bits 15-10 hold OUI bits 19 to 24.
// - Index 3 bits 9-4 model number, bits 3-0 revision.
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_register_set (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Management access from the MAC indirect registers
  input  wire logic        mgmt_wr_i,
  input  wire logic        mgmt_rd_i,
  input  wire logic [4:0]  mgmt_index_i,
  input  wire logic [15:0] mgmt_wdata_i,
  output logic [15:0]      mgmt_rdata_o,
  output logic             mgmt_hit_o,
  // Live PHY conditions
  input  wire logic        link_up_i,
  input  wire logic        remote_fault_i,
  input  wire logic        jabber_i,
  input  wire logic        an_complete_i,
  // Controls to PHY logic
  output logic             soft_reset_o,
  output logic             loopback_o,
  output logic             speed_100_o,
  output logic             full_duplex_o,
  output logic             an_enable_o,
  output logic             an_restart_o,
  output logic             power_down_o,
  output logic             col_test_o
);
  mgmt_if bus ();

  logic        sel_control;
  logic        sel_status;
  logic        sel_oui_high;
  logic        sel_oui_model;
  logic [15:0] control_word;
  logic [15:0] status_word;
  logic        wr_control;
  logic        rd_status;

  // Soft reset sequencing
  logic        soft_rst_q;
  logic [3:0]  soft_cnt_q;
  logic        soft_done;

  // Control fields
  logic        loopback_q;
  logic        speed_q;
  logic        an_en_q;
  logic        pdown_q;
  logic        restart_q;
  logic        duplex_q;
  logic        col_q;

  // Latched status
  logic        rfault_q;
  logic        jabber_q;
  logic        link_q;

  // Identifiers, software writable
  logic [15:0] oui_high_q;
  logic [15:0] oui_model_q;

  assign bus.wr_en = mgmt_wr_i;
  assign bus.rd_en = mgmt_rd_i;
  assign bus.index = mgmt_index_i;
  assign bus.wdata = mgmt_wdata_i;

  phy_index_decode u_decode (
    .bus             (bus.decoder),
    .control_i       (control_word),
    .status_i        (status_word),
    .oui_high_i      (oui_high_q),
    .oui_model_i     (oui_model_q),
    .sel_control_o   (sel_control),
    .sel_status_o    (sel_status),
    .sel_oui_high_o  (sel_oui_high),
    .sel_oui_model_o (sel_oui_model)
  );

  assign wr_control = mgmt_wr_i && sel_control;
  assign rd_status  = mgmt_rd_i && sel_status;
  assign soft_done  = soft_rst_q && (soft_cnt_q == 4'h1);

  always_comb begin
    control_word = 16'h0000;
    control_word[phy_mgmt_pkg::CTL_SOFT_RESET]  = soft_rst_q;
    control_word[phy_mgmt_pkg::CTL_LOOPBACK]    = loopback_q;
    control_word[phy_mgmt_pkg::CTL_SPEED_100]   = speed_q;
    control_word[phy_mgmt_pkg::CTL_AN_ENABLE]   = an_en_q;
    control_word[phy_mgmt_pkg::CTL_POWER_DOWN]  = pdown_q;
    control_word[phy_mgmt_pkg::CTL_AN_RESTART]  = restart_q;
    control_word[phy_mgmt_pkg::CTL_FULL_DUPLEX] = duplex_q;
    control_word[phy_mgmt_pkg::CTL_COL_TEST]    = col_q;
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[15:11] = phy_mgmt_pkg::ABILITY_BITS;
    status_word[phy_mgmt_pkg::STS_AN_COMPLETE]  = an_complete_i;
    status_word[phy_mgmt_pkg::STS_REMOTE_FAULT] = rfault_q;
    status_word[phy_mgmt_pkg::STS_AN_ABILITY]   = 1'b1;
    status_word[phy_mgmt_pkg::STS_LINK_UP]      = link_q;
    status_word[phy_mgmt_pkg::STS_JABBER]       = jabber_q;
    status_word[phy_mgmt_pkg::STS_EXT_CAP]      = 1'b1;
  end

  // Soft reset runs a fixed count then clears itself
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      soft_rst_q <= 1'b0;
      soft_cnt_q <= 4'h0;
    end else if (soft_done) begin
      soft_rst_q <= 1'b0;
      soft_cnt_q <= 4'h0;
    end else if (soft_rst_q) begin
      soft_cnt_q <= soft_cnt_q - 4'h1;
    end else if (wr_control && mgmt_wdata_i[phy_mgmt_pkg::CTL_SOFT_RESET]) begin
      soft_rst_q <= 1'b1;
      soft_cnt_q <= phy_mgmt_pkg::SOFT_RESET_CYCLES;
    end
  end

  // Control fields return to defaults while soft reset runs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      loopback_q <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_LOOPBACK];
      speed_q    <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_SPEED_100];
      an_en_q    <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_AN_ENABLE];
      pdown_q    <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_POWER_DOWN];
      duplex_q   <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_FULL_DUPLEX];
      col_q      <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_COL_TEST];
    end else if (soft_rst_q) begin
      loopback_q <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_LOOPBACK];
      speed_q    <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_SPEED_100];
      an_en_q    <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_AN_ENABLE];
      pdown_q    <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_POWER_DOWN];
      duplex_q   <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_FULL_DUPLEX];
      col_q      <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_COL_TEST];
    end else if (wr_control && !mgmt_wdata_i[phy_mgmt_pkg::CTL_SOFT_RESET]) begin
      // A reset write carries zeros elsewhere; they are not taken
      loopback_q <= mgmt_wdata_i[phy_mgmt_pkg::CTL_LOOPBACK];
      speed_q    <= mgmt_wdata_i[phy_mgmt_pkg::CTL_SPEED_100];
      an_en_q    <= mgmt_wdata_i[phy_mgmt_pkg::CTL_AN_ENABLE];
      pdown_q    <= mgmt_wdata_i[phy_mgmt_pkg::CTL_POWER_DOWN];
      duplex_q   <= mgmt_wdata_i[phy_mgmt_pkg::CTL_FULL_DUPLEX];
      col_q      <= mgmt_wdata_i[phy_mgmt_pkg::CTL_COL_TEST];
    end
  end

  // Restart reads back 1 for a single cycle, as a pulse into the negotiator
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      restart_q <= 1'b0;
    end else if (restart_q || soft_rst_q) begin
      restart_q <= 1'b0;
    end else if (wr_control && !mgmt_wdata_i[phy_mgmt_pkg::CTL_SOFT_RESET]) begin
      restart_q <= mgmt_wdata_i[phy_mgmt_pkg::CTL_AN_RESTART];
    end
  end

  // Latched status; a new event in the read cycle wins over the clear
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rfault_q <= 1'b0;
      jabber_q <= 1'b0;
      link_q   <= 1'b0;
    end else if (soft_rst_q) begin
      rfault_q <= 1'b0;
      jabber_q <= 1'b0;
      link_q   <= 1'b0;
    end else begin
      rfault_q <= remote_fault_i || (rfault_q && !rd_status);
      jabber_q <= jabber_i || (jabber_q && !rd_status);
      link_q   <= link_up_i && (link_q || rd_status);
    end
  end

  // Identifiers are kept over soft reset; only the pin reset restores them
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oui_high_q  <= phy_mgmt_pkg::OUI_HIGH_RESET;
      oui_model_q <= phy_mgmt_pkg::OUI_MODEL_RESET;
    end else if (mgmt_wr_i && sel_oui_high) begin
      oui_high_q  <= mgmt_wdata_i;
    end else if (mgmt_wr_i && sel_oui_model) begin
      oui_model_q <= mgmt_wdata_i;
    end
  end

  // Read data registered; forced speed and duplex yield to negotiation
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mgmt_rdata_o  <= 16'h0000;
      mgmt_hit_o    <= 1'b0;
      soft_reset_o  <= 1'b0;
      loopback_o    <= 1'b0;
      speed_100_o   <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_SPEED_100];
      full_duplex_o <= 1'b0;
      an_enable_o   <= phy_mgmt_pkg::CONTROL_RESET[phy_mgmt_pkg::CTL_AN_ENABLE];
      an_restart_o  <= 1'b0;
      power_down_o  <= 1'b0;
      col_test_o    <= 1'b0;
    end else begin
      mgmt_rdata_o  <= mgmt_rd_i ? bus.rdata : mgmt_rdata_o;
      mgmt_hit_o    <= bus.hit;
      soft_reset_o  <= soft_rst_q;
      loopback_o    <= loopback_q;
      speed_100_o   <= an_en_q ? 1'b1 : speed_q;
      full_duplex_o <= an_en_q ? 1'b0 : duplex_q;
      an_enable_o   <= an_en_q;
      an_restart_o  <= restart_q;
      power_down_o  <= pdown_q;
      col_test_o    <= col_q;
    end
  end
endmodule
`default_nettype wire

// *** tb/phy_mgmt_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_monitor (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  // Management access
  input wire logic        mgmt_wr_i,
  input wire logic        mgmt_rd_i,
  input wire logic [4:0]  mgmt_index_i,
  input wire logic [15:0] mgmt_wdata_i,
  input wire logic [15:0] mgmt_rdata_o,
  input wire logic        mgmt_hit_o,
  // Live conditions
  input wire logic        link_up_i,
  input wire logic        remote_fault_i,
  input wire logic        jabber_i,
  input wire logic        an_complete_i,
  // Controls
  input wire logic        soft_reset_o,
  input wire logic        loopback_o,
  input wire logic        speed_100_o,
  input wire logic        full_duplex_o,
  input wire logic        an_enable_o,
  input wire logic        an_restart_o,
  input wire logic        power_down_o,
  input wire logic        col_test_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic rd_sts = mgmt_rd_i && mgmt_index_i == 5'h01;
  wire logic wr_ctl = mgmt_wr_i && mgmt_index_i == 5'h00 && !soft_reset_o;
  wire logic known = mgmt_index_i inside {[5'h00:5'h06], 5'h11, 5'h12, 5'h1b, [5'h1d:5'h1f]};
  AST_STS_FIXED: assert property (rd_sts |=> {mgmt_rdata_o[15:6], mgmt_rdata_o[3],
    mgmt_rdata_o[0]} == 12'h783) else $error("fixed status bits wrong");
  AST_AN_DONE: assert property (rd_sts |=> mgmt_rdata_o[5] == $past(an_complete_i))
    else $error("an complete bit wrong");
  // Latched bits show the event one cycle late, so look at the cycle before the read
  AST_FAULT: assert property (rd_sts && $past(remote_fault_i) && !soft_reset_o
    |=> mgmt_rdata_o[4]) else $error("remote fault not reported");
  AST_JABBER: assert property (rd_sts && $past(jabber_i) && !soft_reset_o
    |=> mgmt_rdata_o[1]) else $error("jabber not reported");
  AST_LINK: assert property (rd_sts && !$past(link_up_i) |=> !mgmt_rdata_o[2])
    else $error("link down not reported");
  AST_UNMAPPED: assert property (mgmt_rd_i && mgmt_index_i > 5'h03 |=> mgmt_rdata_o == 16'h0000)
    else $error("unimplemented index not zero");
  AST_HIT: assert property (mgmt_rd_i |=> mgmt_hit_o == $past(known))
    else $error("index decode wrong");
  AST_CTL_RSVD: assert property (mgmt_rd_i && mgmt_index_i == 5'h00 |=>
    mgmt_rdata_o[10] == 1'b0 && mgmt_rdata_o[6:0] == 7'h00) else $error("reserved bits set");
  AST_SR_START: assert property (wr_ctl && mgmt_wdata_i[15] |-> ##[1:3] soft_reset_o)
    else $error("soft reset not started");
  AST_SR_LEN: assert property ($rose(soft_reset_o) |-> soft_reset_o [*8] ##1 soft_reset_o
    ##1 soft_reset_o ##1 !soft_reset_o) else $error("soft reset length wrong");
  AST_SR_DEF: assert property (soft_reset_o [*3] |-> an_enable_o && speed_100_o &&
    !loopback_o && !power_down_o && !col_test_o) else $error("soft reset defaults wrong");
  AST_AN_OVR: assert property (an_enable_o [*2] |-> speed_100_o && !full_duplex_o)
    else $error("forced mode not overridden");
  // Soft reset shows on its pin a cycle late; a write it swallowed must not count
  AST_RESTART: assert property (wr_ctl && mgmt_wdata_i[9] && !mgmt_wdata_i[15]
    ##1 !soft_reset_o |-> ##1 an_restart_o ##1 !an_restart_o) else $error("restart pulse wrong");
endmodule
bind phy_mgmt_register_set phy_mgmt_monitor u_monitor (.*);
`default_nettype wire

// *** tb/mac_mgmt_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mac_mgmt_model (
  // Clock
  input  wire logic        core_clk_i,
  // Indexed access toward the PHY registers
  output logic             mgmt_wr_o,
  output logic             mgmt_rd_o,
  output logic [4:0]       mgmt_index_o,
  output logic [15:0]      mgmt_wdata_o,
  input  wire logic [15:0] mgmt_rdata_i
);
  initial begin
    {mgmt_wr_o, mgmt_rd_o, mgmt_index_o, mgmt_wdata_o} = 23'h000000;
  end
  // Every access goes by index through this one path
  task automatic xfer(input logic wr, input logic [4:0] i, input logic [15:0] d,
                      output logic [15:0] q);
    @(posedge core_clk_i) #1;
    mgmt_index_o = i;
    mgmt_wdata_o = (i == 5'h00 && d[15]) ? 16'h8000 : d;
    {mgmt_wr_o, mgmt_rd_o} = {wr, !wr};
    @(posedge core_clk_i) #1;
    {mgmt_wr_o, mgmt_rd_o} = 2'b00;
    // Idle lines change so a stale word is never mistaken for a request
    mgmt_index_o = ~i;
    mgmt_wdata_o = ~d;
    @(posedge core_clk_i) #1;
    q = mgmt_rdata_i;
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0, mgmt_wr_i, mgmt_rd_i, mgmt_hit_o;
  logic [4:0]  mgmt_index_i;
  logic [15:0] mgmt_wdata_i, mgmt_rdata_o, q, d;
  logic        link_up_i = 1'b1, remote_fault_i = 1'b0, jabber_i = 1'b0, an_complete_i = 1'b0;
  logic        soft_reset_o, loopback_o, speed_100_o, full_duplex_o;
  logic        an_enable_o, an_restart_o, power_down_o, col_test_o;
  logic [31:0] lfsr = 32'h88c90b45;
  int          n_errors = 0, n_tests = 0, cycles = 0;
  wire logic [5:0] outs = {loopback_o, speed_100_o, full_duplex_o, an_enable_o, power_down_o,
                           col_test_o};
  always #50 core_clk_i = ~core_clk_i;
  phy_mgmt_register_set uut (.*);
  mac_mgmt_model mac (.core_clk_i(core_clk_i), .mgmt_wr_o(mgmt_wr_i), .mgmt_rd_o(mgmt_rd_i),
    .mgmt_index_o(mgmt_index_i), .mgmt_wdata_o(mgmt_wdata_i), .mgmt_rdata_i(mgmt_rdata_o));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_sts(input logic an, rf, lk, jb);
    return {5'h0f, 5'h00, an, rf, 1'b1, lk, jb, 1'b1};
  endfunction
  // Forced speed and duplex only show once auto-negotiation is off
  function automatic logic [15:0] exp_outs(input logic [15:0] c);
    return {10'h000, c[14], c[12] | c[13], c[8] & !c[12], c[12], c[11], c[7]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic rd(input logic [4:0] i);
    mac.xfer(1'b0, i, 16'h0000, q);
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] v);
    mac.xfer(1'b1, i, v, q);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk_i);
    #1 rst_b_i = 1'b1;
    chk({10'h000, outs}, exp_outs(16'h3000));
    rd(5'h00); chk(q, 16'h3000);
    rd(5'h02); chk(q, phy_mgmt_pkg::OUI_HIGH_RESET);
    rd(5'h03); chk(q, phy_mgmt_pkg::OUI_MODEL_RESET);
    rd(5'h01); chk(q, exp_sts(1'b0, 1'b0, 1'b0, 1'b0));
    rd(5'h01); chk(q, exp_sts(1'b0, 1'b0, 1'b1, 1'b0));
    wr(5'h07, 16'hffff);
    for (int i = 4; i < 32; i++) begin
      rd(5'(i)); chk(q, 16'h0000);
    end
    for (int k = 0; k < 16; k++) begin
      lfsr = next_rand(lfsr);
      d = lfsr[15:0] & 16'h7dff;
      if (d[11]) d[12] = 1'b0;
      an_complete_i = lfsr[20];
      wr(5'h00, d);
      rd(5'h00); chk(q, d & 16'h7980);
      chk({10'h000, outs}, exp_outs(d));
      wr(5'h03, lfsr[31:16]);
      rd(5'h03); chk(q, lfsr[31:16]);
      rd(5'h01); chk(q, exp_sts(lfsr[20], 1'b0, 1'b1, 1'b0));
    end
    wr(5'h00, 16'h1200);
    rd(5'h00); chk(q, 16'h1000);
    wr(5'h02, 16'h0f0f);
    wr(5'h00, 16'h4980);
    wr(5'h00, 16'h8000); chk({15'h0000, soft_reset_o}, 16'h0001);
    rd(5'h00); chk(q, 16'hb000);
    wr(5'h00, 16'h4000);
    repeat (12) @(posedge core_clk_i);
    #1 chk({15'h0000, soft_reset_o}, 16'h0000);
    rd(5'h00); chk(q, 16'h3000);
    rd(5'h02); chk(q, 16'h0f0f);
    rd(5'h01);
    {remote_fault_i, jabber_i, link_up_i} = 3'b110;
    @(posedge core_clk_i) #1 {remote_fault_i, jabber_i, link_up_i} = 3'b001;
    rd(5'h01); chk(q, exp_sts(an_complete_i, 1'b1, 1'b0, 1'b1));
    rd(5'h01); chk(q, exp_sts(an_complete_i, 1'b0, 1'b1, 1'b0));
    {remote_fault_i, jabber_i, link_up_i} = 3'b110;
    rd(5'h01); chk(q, exp_sts(an_complete_i, 1'b1, 1'b0, 1'b1));
    {remote_fault_i, jabber_i, link_up_i} = 3'b001;
    rd(5'h01); chk(q, exp_sts(an_complete_i, 1'b1, 1'b0, 1'b1));
    rd(5'h01); chk(q, exp_sts(an_complete_i, 1'b0, 1'b1, 1'b0));
    rst_b_i = 1'b0;
    @(posedge core_clk_i) #1 rst_b_i = 1'b1;
    rd(5'h02); chk(q, phy_mgmt_pkg::OUI_HIGH_RESET);
    finish_test();
  end
endmodule
`default_nettype wire
